// *** three_wire_busy_handshake_test.sv ***
/*
 Bench joining master and slave through the link interface.
 Assumes 100 MHz clk; start and tx_load are one-edge pulses.
*/
`timescale 1ns/1ps
module three_wire_busy_handshake_test;
   import tw_link_pkg::*;
   logic  clk = 0, rst = 1, tx_valid = 0, rx_ready = 0, start = 0;
   logic  tx_load = 0, done_clear = 0, tx_ready, rx_valid;
   logic  m_pend, m_done, m_irq, s_done, s_irq;
   logic  [7:0] m_mode, s_mode;
   word_t tx_data = 8'h00, s_tx = 8'h00, rx_data, s_rx, mw, sw;
   word_t tab[4] = '{8'h80, 8'hFF, 8'h01, 8'h5A};
   int    failures = 0, n_compared = 0, i, k;

   tw_link_if link ();
   tw_master tw_master_inst (.clk(clk), .rst(rst), .link(link), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .start(start), .pending_busy_flag(m_pend),
      .transfer_done_flag(m_done), .serial_end_interrupt(m_irq), .serial_mode_setting(m_mode));
   tw_slave tw_slave_inst (.clk(clk), .rst(rst), .link(link), .tx_load(tx_load),
      .tx_data(s_tx), .rx_data(s_rx), .transfer_done_flag(s_done), .done_clear(done_clear),
      .serial_end_interrupt(s_irq), .serial_mode_setting(s_mode));
   tw_link_checker checker_inst (.clk(clk), .rst(rst), .sck(link.sck),
      .m_to_s(link.m_to_s), .s_to_m(link.s_to_m), .ready_n_busy(link.ready_n_busy));

   always #5 clk = ~clk;

   // Bits as the master sees them, taken at the sampling edge
   always @(posedge link.sck) begin
      mw <= {mw[6:0], link.m_to_s};
      sw <= {sw[6:0], link.s_to_m};
   end

   task cmp(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task push(input word_t w);
      @(posedge clk) tx_valid <= 1;
      tx_data <= w;
      do @(posedge clk); while (tx_ready !== 1'b1);
      tx_valid <= 0;
   endtask

   task load(input word_t w);
      @(posedge clk) tx_load <= 1;
      s_tx <= w;
      @(posedge clk) tx_load <= 0;
   endtask

   task go;
      @(posedge clk) start <= 1;
      @(posedge clk) start <= 0;
   endtask

   task wait_end;
      for (i = 0; i < 300; i++) begin
         @(negedge clk);
         if (m_irq === 1'b1) break;
      end
      cmp(i < 300, 8'h01);
   endtask

   task pop(input word_t e);
      @(negedge clk) cmp(rx_valid, 8'h01);
      cmp(rx_data, e);
      @(posedge clk) rx_ready <= 1;
      @(posedge clk) rx_ready <= 0;
   endtask

   task stop_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // About 1350 cycles of traffic; four times that plus margin
   initial begin
      #60us;
      failures++;
      stop_test;
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      cmp(m_mode, 8'h83);
      cmp(s_mode, 8'h80);
      push(8'hA5);
      go;
      repeat (2) @(negedge clk);
      cmp(m_pend, 8'h01);
      cmp(m_done, 8'h00);
      load(8'h3C);
      go;
      wait_end;
      @(negedge clk) cmp(m_done, 8'h01);
      cmp(s_irq, 8'h01);
      cmp(m_irq, 8'h00);
      cmp(m_pend, 8'h00);
      cmp(s_done, 8'h01);
      cmp(s_rx, 8'hA5);
      cmp(mw, 8'hA5);
      cmp(sw, 8'h3C);
      pop(8'h3C);
      cmp(link.ready_n_busy, 8'h00);
      @(posedge clk) done_clear <= 1;
      @(posedge clk) done_clear <= 0;
      @(negedge clk) cmp(s_done, 8'h00);
      $display("test retry done");
      for (k = 0; k < 4; k++) push(tab[k]);
      @(negedge clk) cmp(tx_ready, 8'h00);
      // Slave still busy from the last frame: start must be refused
      go;
      repeat (2) @(negedge clk);
      cmp(m_pend, 8'h01);
      for (k = 0; k < 4; k++) begin
         load(~tab[k]);
         go;
         wait_end;
         @(negedge clk) cmp(s_rx, tab[k]);
      end
      for (k = 0; k < 4; k++) pop(~tab[k]);
      $display("test fifo done");
      stop_test;
   end
endmodule // three_wire_busy_handshake_test

// *** tw_fifo.sv ***
/*
 Small valid/ready FIFO with parameter width and depth.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module tw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   logic             full;
   logic             empty;
   assign empty     = (wp_q == rp_q);
   assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_q[AW-1:0]];
   always_ff @(posedge clk) begin
      if (in_valid && !full) mem[wp_q[AW-1:0]] <= in_data;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (in_valid && !full) wp_q <= wp_q + 1'b1;
         if (out_ready && !empty) rp_q <= rp_q + 1'b1;
      end
   end
endmodule // tw_fifo

// *** tw_link_cfg.svh ***
/*
 Constants for the three-wire link with busy handshake.
 Assumes inclusion by bare name from the package and both ends.
*/
`ifndef TW_LINK_CFG_SVH
`define TW_LINK_CFG_SVH
`define TW_WORD_BITS     8
`define TW_CLK_DIV       32
`define TW_HALF_DIV      16
`define TW_CNT_W         3
`define TW_DIV_W         5
`define TW_MODE_MASTER   8'h83
`define TW_MODE_SLAVE    8'h80
`define TW_FIFO_DEPTH    4
`define TW_END_SETTLE    2
`endif

// *** tw_link_checker.sv ***
/*
 Checker on the link wires: shift clock timing, data and busy.
 Assumes clk is shared by both ends and rst is async active high.
*/
`timescale 1ns/1ps
module tw_link_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic m_to_s,
   input wire logic s_to_m,
   input wire logic ready_n_busy
);
   logic [3:0] n_q;
   logic       rdy_q;
   logic       sck_q;

   // Pulse count per frame; a busy release opens a new frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         n_q   <= 4'h0;
         rdy_q <= 1'b0;
         sck_q <= 1'b0;
      end else begin
         rdy_q <= ready_n_busy;
         sck_q <= sck;
         if (ready_n_busy && !rdy_q) n_q <= 4'h0;
         else if (sck && !sck_q) n_q <= n_q + 4'h1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_high_half: assert property ($rose(sck) |-> ##16 $fell(sck))
      else $error("sck high half wrong");
   a_rise_period: assert property ($rose(sck) && n_q != 4'h7 |-> ##32 $rose(sck))
      else $error("sck period wrong");
   a_start_needs_ready: assert property ($rose(sck) |-> $past(ready_n_busy, 16))
      else $error("frame began while busy");
   a_no_clk_busy: assert property (!ready_n_busy |-> !sck)
      else $error("sck high while busy");
   a_data_stable: assert property (sck && $past(sck) |-> $stable(m_to_s) && $stable(s_to_m))
      else $error("data moved while sck high");
   a_eight_pulses: assert property ($fell(ready_n_busy) |-> n_q == 4'h8)
      else $error("frame pulse count not eight");
   a_busy_after_end: assert property ($fell(sck) && n_q == 4'h8 |-> ##[1:4] !ready_n_busy)
      else $error("busy not raised at end");
   a_clk_stops: assert property ($fell(sck) && n_q == 4'h8 |=> !sck [*8])
      else $error("sck ran after last pulse");
endmodule // tw_link_checker

// *** tw_link_if.sv ***
/*
 Link wires between master and slave: clock, two data lines, busy.
 Assumes both ends share clk; the master makes the shift clock.
*/
`timescale 1ns/1ps
interface tw_link_if;
   logic sck;
   logic m_to_s;
   logic s_to_m;
   logic ready_n_busy;
   modport master (output sck, output m_to_s, input s_to_m, input ready_n_busy);
   modport slave  (input sck, input m_to_s, output s_to_m, output ready_n_busy);
endinterface

// *** tw_link_pkg.sv ***
/*
 Types shared by both ends of the three-wire link.
 Assumes the constants header is on the include path.
*/
`include "tw_link_cfg.svh"
package tw_link_pkg;
   typedef logic [`TW_WORD_BITS-1:0] word_t;
   typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH} m_state_t;
   typedef enum logic [1:0] {S_BUSY, S_READY, S_DONE} s_state_t;
endpackage

// *** tw_master.sv ***
/*
 Master end: makes the shift clock, checks busy, shifts 8 bits MSB first.
 Assumes the slave shares clk and keeps its own handshake duties.
// Operation
// R1: Link is clock, two data wires, busy
// R2: Slave drives busy, low means busy
// R3: One 8-bit word, MSB first
// R4: Master clock is system clock over 32
// R5: Start only after transmit word loaded
// R6: Busy low: skip, set pending-busy flag
// R7: Pending-busy means retry later
// R8: Master mode: three-wire, MSB first, internal clock
// R9: Slave mode: takes clock from master
// R10: Slave shifts word both ways together
// R11: Slave busy while preparing word
// R12: Slave releases busy once word loaded
// R13: Slave busy again at end interrupt
// R14: Slave busy after transfer until reload
// R15: End interrupt stores word, sets done
// R16: Count eight pulses, stop clock, complete
*/
`timescale 1ns/1ps
`include "tw_link_cfg.svh"
module tw_master #(
   parameter int WORD_BITS  = `TW_WORD_BITS,
   parameter int CLK_DIV    = `TW_CLK_DIV,
   parameter int FIFO_DEPTH = `TW_FIFO_DEPTH
) (
   input  wire logic               clk,
   input  wire logic               rst,
   tw_link_if.master               link,
   input  wire logic               tx_valid,
   output logic                    tx_ready,
   input  wire tw_link_pkg::word_t tx_data,
   output logic                    rx_valid,
   input  wire logic               rx_ready,
   output tw_link_pkg::word_t      rx_data,
   input  wire logic               start,
   output logic                    pending_busy_flag,
   output logic                    transfer_done_flag,
   output logic                    serial_end_interrupt,
   output logic [7:0]              serial_mode_setting
);
   import tw_link_pkg::*;

   // Half shift period in system clocks; one frame is WORD_BITS periods
   localparam int HALF_DIV = CLK_DIV / 2;
   localparam int DIV_W    = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
   localparam int CNT_W    = (WORD_BITS > 1) ? $clog2(WORD_BITS) : 1;

   if (WORD_BITS != $bits(word_t)) begin : g_bad_width
      $error("WORD_BITS must match the link word type");
   end
   if (CLK_DIV < 4 || (CLK_DIV % 2) != 0) begin : g_bad_div
      $error("CLK_DIV must be even and at least 4");
   end
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      m_state_t         st;
      logic [DIV_W-1:0] div;
      logic [CNT_W-1:0] bits;
      logic [1:0]       settle;
      word_t            shift_buffer;
      word_t            rx_word;
      logic             sck;
      logic             busy_flag;
      logic             done_flag;
      logic             end_irq;
   } m_reg_t;

   // Idle: shift clock low, flags clear
   localparam m_reg_t RESET_Q = '{
      st:           M_IDLE,
      div:          '0,
      bits:         '0,
      settle:       '0,
      shift_buffer: '0,
      rx_word:      '0,
      sck:          1'b0,
      busy_flag:    1'b0,
      done_flag:    1'b0,
      end_irq:      1'b0
   };

   m_reg_t q;
   m_reg_t d;
   logic   fifo_valid;
   logic   fifo_ready;
   word_t  fifo_data;
   logic   rx_fifo_ready;
   logic   half_end;
   logic   last_bit;
   logic   can_start;
   logic   settled;

   assign half_end  = (q.div == DIV_W'(HALF_DIV - 1));
   assign last_bit  = (q.bits == CNT_W'(WORD_BITS - 1));
   assign can_start = start && fifo_valid && rx_fifo_ready;
   assign settled   = (q.settle == 2'h0);

   tw_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (fifo_data)
   );

   tw_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (q.end_irq),
      .in_ready  (rx_fifo_ready),
      .in_data   (q.rx_word),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   // Slave drops busy a clock after the frame ends; a start in that
   // gap would trust a stale high busy line, so starts wait it out
   always_comb begin
      d          = q;
      d.end_irq  = 1'b0;
      fifo_ready = 1'b0;
      if (!settled) begin
         d.settle = q.settle - 2'h1;
      end
      case (q.st)
         M_IDLE: begin
            d.sck = 1'b0;
            d.div = '0;
            // Busy sampled only at the start decision [R6]
            if (can_start && settled) begin
               if (link.ready_n_busy) begin
                  fifo_ready     = 1'b1;
                  d.shift_buffer = fifo_data; // [R5]
                  d.busy_flag    = 1'b0;
                  d.done_flag    = 1'b0;
                  d.bits         = '0;
                  d.st           = M_LOW;
               end else begin
                  // Word stays queued so the user may retry [R6] [R7]
                  d.busy_flag = 1'b1;
               end
            end
         end
         M_LOW: begin
            d.div = q.div + 1'b1;
            if (half_end) begin // [R4]
               // Rising shift clock takes the slave's bit [R3]
               d.sck     = 1'b1;
               d.div     = '0;
               d.rx_word = {q.rx_word[WORD_BITS-2:0], link.s_to_m};
               d.st      = M_HIGH;
            end
         end
         M_HIGH: begin
            d.div = q.div + 1'b1;
            if (half_end) begin // [R4]
               // Falling shift clock presents the next bit [R3]
               d.sck          = 1'b0;
               d.div          = '0;
               d.shift_buffer = {q.shift_buffer[WORD_BITS-2:0], 1'b0};
               d.bits         = q.bits + 1'b1;
               if (last_bit) begin // [R16]
                  d.st        = M_IDLE;
                  d.settle    = 2'(`TW_END_SETTLE);
                  d.end_irq   = 1'b1; // [R15]
                  d.done_flag = 1'b1; // [R15]
               end else begin
                  d.st = M_LOW;
               end
            end
         end
         default: begin
            d.st  = M_IDLE;
            d.sck = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= RESET_Q;
      end else begin
         q <= d;
      end
   end

   assign link.sck             = q.sck; // [R1]
   assign link.m_to_s          = q.shift_buffer[WORD_BITS-1];
   assign pending_busy_flag    = q.busy_flag;
   assign transfer_done_flag   = q.done_flag;
   assign serial_end_interrupt = q.end_irq;
   assign serial_mode_setting  = `TW_MODE_MASTER; // [R8]
endmodule // tw_master

// *** tw_slave.sv ***
/*
 Slave end: shifts on the master's clock, drives active-low busy.
 Assumes the master shares clk and the link clock is a sampled level.
*/
`timescale 1ns/1ps
`include "tw_link_cfg.svh"
module tw_slave (
   input  wire logic               clk,
   input  wire logic               rst,
   tw_link_if.slave                link,
   input  wire logic               tx_load,
   input  wire tw_link_pkg::word_t tx_data,
   output tw_link_pkg::word_t      rx_data,
   output logic                    transfer_done_flag,
   input  wire logic               done_clear,
   output logic                    serial_end_interrupt,
   output logic [7:0]              serial_mode_setting
);
   import tw_link_pkg::*;
   typedef struct packed {
      s_state_t             st;
      logic                 sck_d;
      logic [`TW_CNT_W-1:0] bits;
      word_t                shift_buffer;
      word_t                rx_word;
      logic                 ready;
      logic                 done_flag;
      logic                 end_irq;
   } s_reg_t;
   s_reg_t q;
   s_reg_t d;
   always_comb begin
      d         = q;
      d.end_irq = 1'b0;
      d.sck_d   = link.sck;
      if (done_clear) d.done_flag = 1'b0;
      case (q.st)
         S_BUSY, S_DONE: begin
            if (tx_load) begin
               d.shift_buffer = tx_data;
               d.ready        = 1'b1; // [R12]
               d.bits         = '0;
               d.st           = S_READY;
            end
         end
         S_READY: begin
            if (link.sck && !q.sck_d) begin
               d.rx_word = {q.rx_word[`TW_WORD_BITS-2:0], link.m_to_s}; // [R10]
            end
            if (!link.sck && q.sck_d) begin
               d.shift_buffer = {q.shift_buffer[`TW_WORD_BITS-2:0], 1'b0}; // [R3]
               d.bits = q.bits + 1'b1;
               if (q.bits == (`TW_CNT_W)'(`TW_WORD_BITS - 1)) begin
                  d.ready     = 1'b0; // [R13] [R14]
                  d.end_irq   = 1'b1;
                  d.done_flag = 1'b1;
                  d.st        = S_DONE;
               end
            end
         end
         default: d.st = S_BUSY;
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Busy from reset: no word prepared yet [R11]
         q <= '{st: S_BUSY, default: '0};
      end else begin
         q <= d;
      end
   end
   assign link.ready_n_busy    = q.ready; // [R2]
   assign link.s_to_m          = q.shift_buffer[`TW_WORD_BITS-1];
   assign rx_data              = q.rx_word;
   assign transfer_done_flag   = q.done_flag;
   assign serial_end_interrupt = q.end_irq;
   assign serial_mode_setting  = `TW_MODE_SLAVE; // [R9]
endmodule // tw_slave
